// >>> sdpd_ctrl_model.sv
// Purpose: Memory-controller model driving select, enable and bus.
// Assumes: Each command is followed by a deselected cycle.
// Notes:   The last send cycle and each wait_nop cycle carry the inverse of the last value; set_cke holds it.
`timescale 1ns/1ns
`default_nettype none
module sdpd_ctrl_model
    import sdpd_pkg::*;
(
    input  wire logic            clk,
    output var  logic            cs_n,
    output var  logic            cke,
    output var  logic [CA_W-1:0] cmd_addr_bus
);
    // Deselected, enable high
    initial
    begin
        cs_n = 1'b1;
        cke = 1'b1;
        cmd_addr_bus = '0;
    end

    // Rising half, falling half, then deselect
    task automatic send(input logic ck, input logic [CA_W-1:0] r,
                        input logic [CA_W-1:0] f);
        @(posedge clk);
        cs_n <= 1'b0;
        cke <= ck;
        cmd_addr_bus <= r;
        @(posedge clk);
        cs_n <= 1'b1;
        cmd_addr_bus <= f;
        @(posedge clk);
        cmd_addr_bus <= ~f;
    endtask : send

    // Enable change while deselected
    task automatic set_cke(input logic ck);
        @(posedge clk);
        cke <= ck;
    endtask : set_cke

    // Deselected cycles, e.g. through an exit interval
    task automatic wait_nop(input int n);
        repeat (n) @(posedge clk) cmd_addr_bus <= ~cmd_addr_bus;
    endtask : wait_nop
endmodule : sdpd_ctrl_model
`default_nettype wire

// >>> sdpd_decoder.sv
// Purpose: Command and clock-enable state decoder of a low-power DDR
//          memory: normal decode, NOP, power-down, self refresh, deep
//          sleep entry and exit.
// Assumes: Inputs synchronous to clk; the falling half of each command
//          is taken on the falling edge after its rising edge.
// Notes:   Decisions for edge n are registered at edge n+1.
`timescale 1ns/1ns
`default_nettype none
module sdpd_decoder
    import sdpd_pkg::*;
#(
    parameter int unsigned NUM_BANKS       = DEF_NUM_BANKS,
    parameter int unsigned FINAL_INIT_US   = DEF_FINAL_INIT_US,
    parameter int unsigned AP_CLOSE_CYC    = DEF_AP_CLOSE_CYC,
    parameter logic [7:0]  RESET_MODE_ADDR = DEF_RESET_MODE_ADDR
)
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 cs_n,
    input  wire logic                 cke,
    input  wire logic [CA_W-1:0]      cmd_addr_bus,
    output var  sdpd_cmd_t            cmd_out,
    output var  sdpd_state_t          state,
    output logic [NUM_BANKS-1:0]      bank_open,
    output logic                      illegal,
    output logic                      init_expired
);

    // Derived counts
    localparam int unsigned INIT_CYCLES =
        (FINAL_INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [INIT_W-1:0] INIT_LOAD = INIT_CYCLES[INIT_W-1:0];
    localparam logic [AP_W-1:0]   AP_LOAD   = AP_CLOSE_CYC[AP_W-1:0];
    localparam logic PER_BANK_OK = (NUM_BANKS == PER_BANK_REF_BANKS);
    localparam logic [BA_W-1:0] BANK_LIMIT = BA_W'(NUM_BANKS - 1);

    if (NUM_BANKS != PER_BANK_REF_BANKS && NUM_BANKS != ALT_NUM_BANKS)
    begin : g_bad_banks
        $error("sdpd_decoder: NUM_BANKS must be 4 or 8");
    end
    if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << INIT_W))
    begin : g_bad_init
        $error("sdpd_decoder: FINAL_INIT_US out of range");
    end
    if (AP_CLOSE_CYC < 1 || AP_CLOSE_CYC >= (1 << AP_W))
    begin : g_bad_ap
        $error("sdpd_decoder: AP_CLOSE_CYC out of range");
    end

    logic              cs_n_q;
    logic              cke_q;
    logic              cke_prev;
    logic [CA_W-1:0]   rise_q;
    logic [CA_W-1:0]   fall_q;
    logic [BA_W-1:0]   ap_bank;
    logic              ap_busy;
    logic              ap_done;
    logic              init_done;
    sdpd_state_t       next_state;
    logic [NUM_BANKS-1:0] next_bank_open;
    logic              bad;

    // Select, enable and first half taken at the rising edge
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cs_n_q   <= 1'b1;
            cke_q    <= 1'b0;
            cke_prev <= 1'b0;
            rise_q   <= '0;
        end
        else
        begin
            cs_n_q   <= cs_n;
            cke_q    <= cke;
            cke_prev <= cke_q;
            rise_q   <= cmd_addr_bus;
        end
    end

    // Second half taken at the falling edge; bus bits only
    always_ff @(negedge clk)
    begin
        if (reset)
            fall_q <= '0;
        else
            fall_q <= cmd_addr_bus;
    end

    // Clock-enable pair and command class
    wire logic [1:0] cke_pair = {cke_prev, cke_q};
    wire logic       hi_hi    = (cke_pair == CKE_HH);
    wire logic [3:0] head     = rise_q[3:0];
    wire logic       sel      = !cs_n_q;
    wire logic       is_nop   = cs_n_q || (head[2:0] == CODE_NOP);
    wire logic       csel     = sel && hi_hi && !is_nop;

    wire logic cmd_mrw   = csel && (head == CODE_MRW);
    wire logic cmd_mrr   = csel && (head == CODE_MRR);
    wire logic cmd_refpb = csel && (head == CODE_REF_BANK);
    wire logic cmd_refab = csel && (head == CODE_REF_ALL);
    wire logic cmd_pre   = csel && (head == CODE_PRE);
    wire logic cmd_bst   = csel && (head == CODE_BST);
    wire logic cmd_wr    = csel && (head[2:0] == CODE_WRITE);
    wire logic cmd_rd    = csel && (head[2:0] == CODE_READ);
    wire logic cmd_act   = csel && (head[1:0] == CODE_ACT);
    wire logic self_refresh_state_code = sel && (head[2:0] == CODE_SELF_REFRESH_STATE);
    wire logic dpd_code  = sel && (head[2:0] == CODE_DPD);

    // Fields of both halves
    wire logic [BA_W-1:0]  f_bank = rise_q[BA_LSB +: BA_W];
    wire logic [COL_W-1:0] f_col  = {fall_q[COL_HI_LSB +: COL_HI_W],
                                     rise_q[COL_LO_LSB +: COL_LO_W],
                                     1'b0};
    wire logic [ROW_W-1:0] f_row  = {fall_q[ROW_TOP_LSB +: ROW_TOP_W],
                                     rise_q[ROW_MID_LSB +: ROW_MID_W],
                                     fall_q[ROW_LOW_LSB +: ROW_LOW_W]};
    wire logic [MA_W-1:0]  f_ma   = {fall_q[MA_HI_LSB +: MA_HI_W],
                                     rise_q[MA_LO_LSB +: MA_LO_W]};
    wire logic [OPD_W-1:0] f_opd  = fall_q[OPD_LSB +: OPD_W];
    wire logic             f_ap   = fall_q[AP_POS];
    wire logic             f_all  = rise_q[AB_POS];

    // Bank checks
    wire logic bank_ok  = (f_bank <= BANK_LIMIT);
    wire logic bank_hit = bank_ok && bank_open[f_bank];
    wire logic ready    = (state == st_idle) || (state == st_active);
    wire logic is_reset_ma = (f_ma == RESET_MODE_ADDR);

    // Legality of each command in the current state
    wire logic act_ok   = ready && cmd_act && bank_ok && !bank_hit;
    wire logic rw_ok    = (state == st_active) && (cmd_rd || cmd_wr)
                          && bank_hit;
    wire logic pre_ok   = ready && cmd_pre;
    wire logic refab_ok = (state == st_idle) && cmd_refab;
    wire logic refpb_ok = ready && cmd_refpb && PER_BANK_OK
                          && bank_ok && !bank_hit;
    wire logic mrr_ok   = (ready || state == st_resetting) && cmd_mrr;
    wire logic rst_ok   = cmd_mrw && is_reset_ma
                          && (state == st_idle
                              || state == st_power_on
                              || state == st_resetting);
    wire logic mrw_ok   = (state == st_idle) && cmd_mrw && !is_reset_ma;
    wire logic bst_ok   = (state == st_active) && cmd_bst;
    wire logic cmd_ok   = act_ok || rw_ok || pre_ok || refab_ok
                          || refpb_ok || mrr_ok || rst_ok || mrw_ok
                          || bst_ok;
    wire logic ap_start = rw_ok && f_ap;

    // Operation code of an accepted command
    wire sdpd_op_t f_op =
        act_ok   ? op_activate   :
        rw_ok    ? (cmd_rd ? op_read : op_write) :
        pre_ok   ? op_precharge  :
        refab_ok ? op_ref_all    :
        refpb_ok ? op_ref_bank   :
        mrr_ok   ? op_mrr        :
        (rst_ok || mrw_ok) ? op_mrw :
        bst_ok   ? op_burst_stop : op_none;

    // Auto-precharge close timer; keeps counting through NOPs
    sdpd_timer #(
        .WIDTH (AP_W)
    ) u_ap_timer (
        .clk   (clk),
        .reset (reset),
        .start (ap_start),
        .load  (AP_LOAD),
        .busy  (ap_busy),
        .done  (ap_done)
    );

    // Final initialisation interval timer
    sdpd_timer #(
        .WIDTH (INIT_W)
    ) u_init_timer (
        .clk   (clk),
        .reset (reset),
        .start (rst_ok),
        .load  (INIT_LOAD),
        .busy  (),
        .done  (init_done)
    );

    // Open-bank bookkeeping
    always_comb
    begin
        next_bank_open = bank_open;
        if (ap_done || (ap_start && ap_busy))
            next_bank_open[ap_bank] = 1'b0;
        if (act_ok)
            next_bank_open[f_bank] = 1'b1;
        if (pre_ok && f_all)
            next_bank_open = '0;
        else if (pre_ok)
            next_bank_open[f_bank] = 1'b0;
        if (rst_ok)
            next_bank_open = '0;
    end

    // State transitions from the clock-enable pair
    always_comb
    begin
        next_state = state;
        bad        = 1'b0;
        unique case (cke_pair)
            CKE_LL:
                next_state = state;
            CKE_LH:
            begin
                unique case (state)
                    self_refresh_state:
                        next_state = st_idle;
                    deep_sleep_state:
                        next_state = st_power_on;
                    st_active_pd:
                    begin
                        next_state = cs_n_q ? st_active : state;
                        bad        = !cs_n_q;
                    end
                    st_idle_pd:
                    begin
                        next_state = cs_n_q ? st_idle : state;
                        bad        = !cs_n_q;
                    end
                    st_reset_pd:
                    begin
                        if (cs_n_q)
                            next_state = init_expired ? st_idle
                                                      : st_resetting;
                        bad = !cs_n_q;
                    end
                    default:
                        next_state = state;
                endcase
            end
            CKE_HL:
            begin
                unique case (state)
                    st_active:
                    begin
                        next_state = cs_n_q ? st_active_pd : state;
                        bad        = !cs_n_q;
                    end
                    st_idle:
                    begin
                        if (cs_n_q)
                            next_state = st_idle_pd;
                        else if (self_refresh_state_code)
                            next_state = self_refresh_state;
                        else if (dpd_code)
                            next_state = deep_sleep_state;
                        bad = sel && !self_refresh_state_code && !dpd_code;
                    end
                    st_resetting:
                    begin
                        next_state = cs_n_q ? st_reset_pd : state;
                        bad        = !cs_n_q;
                    end
                    default:
                        bad = (state != st_power_on);
                endcase
            end
            CKE_HH:
            begin
                bad = csel && !cmd_ok;
                if (state == st_active_pd || state == st_idle_pd
                    || state == st_reset_pd
                    || state == self_refresh_state
                    || state == deep_sleep_state)
                    bad = 1'b1;
                else if (rst_ok)
                    next_state = st_resetting;
                else if (state == st_resetting && init_expired)
                    next_state = st_idle;
                else if (ready)
                    next_state = (|next_bank_open) ? st_active
                                                   : st_idle;
            end
        endcase
    end

    // State, banks and fault flag
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state     <= st_power_on;
            bank_open <= '0;
            illegal   <= 1'b0;
            ap_bank   <= '0;
        end
        else
        begin
            state     <= next_state;
            bank_open <= next_bank_open;
            illegal   <= bad;
            if (ap_start)
                ap_bank <= f_bank;
        end
    end

    // Interval over: restart or sleep exit clears it first
    wire logic init_clear = rst_ok || (state == deep_sleep_state
                                       && next_state == st_power_on);

    always_ff @(posedge clk)
    begin
        if (reset)
            init_expired <= 1'b0;
        else if (init_clear)
            init_expired <= 1'b0;
        else if (init_done)
            init_expired <= 1'b1;
    end

    // Accepted command, both halves joined
    always_ff @(posedge clk)
    begin
        if (reset || !cmd_ok)
            cmd_out <= '0;
        else
        begin
            cmd_out.valid              <= 1'b1;
            cmd_out.op                 <= f_op;
            cmd_out.bank               <= f_bank;
            cmd_out.all_banks          <= f_all;
            cmd_out.column             <= f_col;
            cmd_out.auto_precharge_bit <= f_ap;
            cmd_out.row                <= f_row;
            cmd_out.mode_addr          <= f_ma;
            cmd_out.mode_data          <= f_opd;
        end
    end

endmodule : sdpd_decoder
`default_nettype wire

// >>> sdpd_monitor.sv
// Purpose: Port checks of the command and clock-enable decoder.
// Assumes: Answer seen two sampled edges after the command edge.
// Notes:   Bound to every decoder instance.
`timescale 1ns/1ns
`default_nettype none
module sdpd_monitor
    import sdpd_pkg::*;
#(
    parameter int unsigned NUM_BANKS = DEF_NUM_BANKS
)
(
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 cs_n,
    input wire logic                 cke,
    input wire logic [CA_W-1:0]      cmd_addr_bus,
    input wire sdpd_cmd_t            cmd_out,
    input wire sdpd_state_t          state,
    input wire logic [NUM_BANKS-1:0] bank_open,
    input wire logic                 illegal,
    input wire logic                 init_expired
);
    logic [CA_W-1:0] fall_q;

    // Falling-half capture
    always_ff @(negedge clk)
    begin
        fall_q <= cmd_addr_bus;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_nop_quiet: assert property (
        $past(cke,3) && $past(cke,2) && ($past(cs_n,2) ||
        $past(cmd_addr_bus[2:0],2) == CODE_NOP)
        |-> !cmd_out.valid && !illegal) else $error("nop acted");
    a_cmd_taken: assert property (
        $past(cke,3) && $past(cke,2) && !$past(cs_n,2) &&
        $past(cmd_addr_bus[2:0],2) != CODE_NOP
        |-> cmd_out.valid ^ illegal) else $error("command lost");
    a_self_refresh_state_entry: assert property (
        $past(state) == st_idle && $past(cke,3) && !$past(cke,2) &&
        !$past(cs_n,2) && $past(cmd_addr_bus[2:0],2) == CODE_SELF_REFRESH_STATE
        |-> state == self_refresh_state) else $error("no self_refresh_state");
    a_sleep_entry: assert property (
        $past(state) == st_idle && $past(cke,3) && !$past(cke,2) &&
        !$past(cs_n,2) && $past(cmd_addr_bus[2:0],2) == CODE_DPD
        |-> state == deep_sleep_state) else $error("no sleep");
    a_pd_entry: assert property (
        $past(cke,3) && !$past(cke,2) && $past(cs_n,2) &&
        $past(state) inside {st_active, st_idle, st_resetting}
        |-> state == ($past(state) == st_active ? st_active_pd :
        $past(state) == st_idle ? st_idle_pd : st_reset_pd))
        else $error("bad pd entry");
    a_hold_low: assert property (
        !$past(cke,3) && !$past(cke,2) && $past(state) inside
        {st_active_pd, st_idle_pd, st_reset_pd, self_refresh_state,
        deep_sleep_state} |-> state == $past(state))
        else $error("left low power");
    a_exit_low: assert property (
        !$past(cke,3) && $past(cke,2) && $past(cs_n,2) &&
        $past(state) inside {st_active_pd, st_idle_pd,
        self_refresh_state, deep_sleep_state}
        |-> state == ($past(state) == st_active_pd ? st_active :
        $past(state) == deep_sleep_state ? st_power_on : st_idle))
        else $error("bad exit");
    a_col_fields: assert property (
        cmd_out.valid && cmd_out.op inside {op_read, op_write} |->
        cmd_out.bank == $past(cmd_addr_bus[9:7],2) &&
        cmd_out.column == {$past(fall_q[9:1],1),
        $past(cmd_addr_bus[6:5],2), 1'b0} &&
        cmd_out.auto_precharge_bit == $past(fall_q[0],1))
        else $error("column fields wrong");
    a_ref_banks: assert property (
        cmd_out.valid && cmd_out.op == op_ref_bank |-> NUM_BANKS == 8)
        else $error("bank refresh accepted");

    c_self_refresh_state: cover property (state == self_refresh_state);
    c_ap: cover property (cmd_out.valid && cmd_out.auto_precharge_bit);
    c_apd: cover property (state == st_active_pd);
endmodule : sdpd_monitor

bind sdpd_decoder sdpd_monitor #(.NUM_BANKS(NUM_BANKS)) u_mon (
    .clk(clk), .reset(reset), .cs_n(cs_n), .cke(cke),
    .cmd_addr_bus(cmd_addr_bus), .cmd_out(cmd_out), .state(state),
    .bank_open(bank_open), .illegal(illegal),
    .init_expired(init_expired));
`default_nettype wire

// >>> sdpd_pkg.sv
// Purpose: Shared constants and types of the command and clock-enable
//          state decoder.
// Assumes: One 25 MHz clock; command/address bit 0 is the bus's bit 0.
// Notes:   Field positions index the captured rising or falling half.
package sdpd_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS     = 40;
    localparam int unsigned DEF_FINAL_INIT_US = 10;
    localparam int unsigned DEF_AP_CLOSE_CYC  = 8;

    // Bank count and the count that supports per-bank refresh
    localparam int unsigned DEF_NUM_BANKS      = 8;
    localparam int unsigned PER_BANK_REF_BANKS = 8;
    localparam int unsigned ALT_NUM_BANKS      = 4;

    // Mode address that starts device initialisation
    localparam logic [7:0] DEF_RESET_MODE_ADDR = 8'h00;

    // Widths
    localparam int CA_W   = 10;
    localparam int BA_W   = 3;
    localparam int COL_W  = 12;
    localparam int ROW_W  = 15;
    localparam int MA_W   = 8;
    localparam int OPD_W  = 8;
    localparam int INIT_W = 16;
    localparam int AP_W   = 8;

    // Field positions in the rising half
    localparam int BA_LSB     = 7;
    localparam int AB_POS     = 4;
    localparam int COL_LO_LSB = 5;
    localparam int COL_LO_W   = 2;
    localparam int ROW_MID_LSB = 2;
    localparam int ROW_MID_W  = 5;
    localparam int MA_LO_LSB  = 4;
    localparam int MA_LO_W    = 6;

    // Field positions in the falling half
    localparam int AP_POS     = 0;
    localparam int COL_HI_LSB = 1;
    localparam int COL_HI_W   = 9;
    localparam int ROW_TOP_LSB = 8;
    localparam int ROW_TOP_W  = 2;
    localparam int ROW_LOW_LSB = 0;
    localparam int ROW_LOW_W  = 8;
    localparam int MA_HI_LSB  = 0;
    localparam int MA_HI_W    = 2;
    localparam int OPD_LSB    = 2;

    // Command codes on the low bits of the rising half
    localparam logic [3:0] CODE_MRW      = 4'h0;
    localparam logic [3:0] CODE_MRR      = 4'h8;
    localparam logic [3:0] CODE_REF_BANK = 4'h4;
    localparam logic [3:0] CODE_REF_ALL  = 4'hc;
    localparam logic [3:0] CODE_PRE      = 4'hb;
    localparam logic [3:0] CODE_BST      = 4'h3;
    localparam logic [2:0] CODE_WRITE    = 3'h1;
    localparam logic [2:0] CODE_READ     = 3'h5;
    localparam logic [2:0] CODE_NOP      = 3'h7;
    localparam logic [2:0] CODE_SELF_REFRESH_STATE     = 3'h4;
    localparam logic [2:0] CODE_DPD      = 3'h3;
    localparam logic [1:0] CODE_ACT      = 2'h2;

    // Clock-enable pairs {previous edge, current edge}
    localparam logic [1:0] CKE_LL = 2'h0;
    localparam logic [1:0] CKE_LH = 2'h1;
    localparam logic [1:0] CKE_HL = 2'h2;
    localparam logic [1:0] CKE_HH = 2'h3;

    typedef enum logic [3:0] {
        st_power_on, st_resetting, st_idle, st_active,
        st_active_pd, st_idle_pd, st_reset_pd,
        self_refresh_state, deep_sleep_state
    } sdpd_state_t;

    typedef enum logic [3:0] {
        op_none, op_mrw, op_mrr, op_ref_bank, op_ref_all,
        op_activate, op_write, op_read, op_precharge, op_burst_stop
    } sdpd_op_t;

    typedef struct packed {
        logic              valid;
        sdpd_op_t          op;
        logic [BA_W-1:0]   bank;
        logic              all_banks;
        logic [COL_W-1:0]  column;
        logic              auto_precharge_bit;
        logic [ROW_W-1:0]  row;
        logic [MA_W-1:0]   mode_addr;
        logic [OPD_W-1:0]  mode_data;
    } sdpd_cmd_t;

endpackage : sdpd_pkg

// >>> sdpd_timer.sv
// Purpose: Loadable down-counter that signals when its interval ends.
// Assumes: Synchronous active-high reset.
// Notes:   A start while running reloads; a zero load ends at once.
`timescale 1ns/1ns
`default_nettype none
module sdpd_timer #(
    parameter int WIDTH = 16
)
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] load,
    output logic                  busy,
    output logic                  done
);

    localparam logic [WIDTH-1:0] ONE  = {{(WIDTH-1){1'b0}}, 1'b1};
    localparam logic [WIDTH-1:0] ZERO = '0;

    logic [WIDTH-1:0] count;

    if (WIDTH < 2)
    begin : g_bad_width
        $error("sdpd_timer: WIDTH must be at least 2");
    end

    // Count down; done pulses on the last cycle
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count <= ZERO;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else if (start)
        begin
            count <= load;
            busy  <= (load != ZERO);
            done  <= (load == ZERO);
        end
        else
        begin
            done <= busy && (count == ONE);
            if (busy)
            begin
                count <= count - ONE;
                busy  <= (count != ONE);
            end
        end
    end

endmodule : sdpd_timer
`default_nettype wire

// >>> sdram_cke_power_state_decoder_tb.sv
// Purpose: Self-checking bench of the command and enable decoder.
// Assumes: Init interval shortened to 25 cycles.
// Notes:   The controller model drives all command inputs.
`timescale 1ns/1ns
`default_nettype none
module sdram_cke_power_state_decoder_tb
    import sdpd_pkg::*;
;
    logic            clk = 1'b0;
    logic            reset = 1'b1;
    logic            cs_n, cke, illegal, init_expired, f, b;
    logic [CA_W-1:0] bus;
    logic [7:0]      bank_open;
    sdpd_cmd_t       cmd_out, got;
    sdpd_state_t     state;
    int              bad_count = 0;
    int              comparisons = 0;
    int              cycles = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    sdpd_decoder #(.NUM_BANKS(8), .FINAL_INIT_US(1), .AP_CLOSE_CYC(4)) dut (
        .clk(clk), .reset(reset), .cs_n(cs_n), .cke(cke),
        .cmd_addr_bus(bus), .cmd_out(cmd_out), .state(state),
        .bank_open(bank_open), .illegal(illegal),
        .init_expired(init_expired));
    sdpd_ctrl_model ctl (.clk(clk), .cs_n(cs_n), .cke(cke),
        .cmd_addr_bus(bus));

    task automatic give_verdict();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk_bits(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_bits

    // Bounded wait for a state, then compare
    task automatic wait_state(input sdpd_state_t e);
        repeat (40)
        begin
            @(negedge clk);
            if (state === e)
                break;
        end
        chk_bits(state, e);
    endtask : wait_state

    // Catch the one-cycle command and fault pulses
    task automatic wait_cmd();
        f = 1'b0;
        b = 1'b0;
        repeat (6)
        begin
            @(negedge clk);
            if (illegal === 1'b1)
                b = 1'b1;
            if (cmd_out.valid === 1'b1)
            begin
                f = 1'b1;
                got = cmd_out;
            end
        end
    endtask : wait_cmd

    task automatic t_init();
        ctl.send(1'b1, 10'h000, 10'h000);
        wait_state(st_resetting);
        ctl.set_cke(1'b0);
        wait_state(st_reset_pd);
        ctl.set_cke(1'b1);
        wait_state(st_resetting);
        ctl.wait_nop(40);
        chk_bits(init_expired, 1);
        wait_state(st_idle);
    endtask : t_init

    task automatic t_access();
        ctl.send(1'b1, 10'h150, 10'h16a);
        wait_cmd();
        chk_bits(got.mode_addr, 8'h95);
        chk_bits(got.mode_data, 8'h5a);
        ctl.send(1'b1, {3'h5, 5'h15, 2'h2}, 10'h2a5);
        wait_cmd();
        chk_bits(got.row, {2'h2, 5'h15, 8'ha5});
        chk_bits(bank_open, 8'h20);
        ctl.send(1'b1, {3'h5, 2'h3, 5'h01}, {9'h1a5, 1'b0});
        wait_cmd();
        chk_bits(got.op, op_write);
        chk_bits(got.column, {9'h1a5, 2'h3, 1'b0});
        ctl.send(1'b1, {3'h5, 2'h2, 5'h05}, {9'h0c3, 1'b1});
        wait_cmd();
        chk_bits(got.auto_precharge_bit, 1);
        ctl.wait_nop(6);
        chk_bits(bank_open, 8'h00);
        ctl.send(1'b1, 10'h104, 10'h000);
        wait_cmd();
        chk_bits(got.op, op_ref_bank);
        ctl.send(1'b1, 10'h3ff, 10'h3ff);
        wait_cmd();
        chk_bits(f, 0);
        chk_bits(b, 0);
        ctl.send(1'b1, 10'h005, 10'h000);
        wait_cmd();
        chk_bits({f, b}, 2'b01);
    endtask : t_access

    task automatic t_power_down();
        ctl.set_cke(1'b0);
        wait_state(st_idle_pd);
        ctl.send(1'b0, 10'h155, 10'h2aa);
        ctl.wait_nop(2);
        chk_bits(state, st_idle_pd);
        ctl.set_cke(1'b1);
        wait_state(st_idle);
        ctl.wait_nop(4);
        ctl.send(1'b1, 10'h082, 10'h000);
        wait_state(st_active);
        ctl.set_cke(1'b0);
        wait_state(st_active_pd);
        ctl.set_cke(1'b1);
        wait_state(st_active);
        ctl.wait_nop(4);
        ctl.send(1'b1, 10'h01b, 10'h000);
        wait_state(st_idle);
    endtask : t_power_down

    task automatic t_sleep();
        ctl.send(1'b0, 10'h004, 10'h000);
        wait_state(self_refresh_state);
        ctl.wait_nop(3);
        chk_bits(state, self_refresh_state);
        ctl.set_cke(1'b1);
        wait_state(st_idle);
        ctl.wait_nop(4);
        ctl.send(1'b0, 10'h003, 10'h000);
        wait_state(deep_sleep_state);
        ctl.set_cke(1'b1);
        wait_state(st_power_on);
        chk_bits(init_expired, 0);
        ctl.send(1'b1, 10'h000, 10'h000);
        wait_state(st_resetting);
    endtask : t_sleep

    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_init();
        t_access();
        t_power_down();
        t_sleep();
        give_verdict();
    end
endmodule : sdram_cke_power_state_decoder_tb
`default_nettype wire
